// ===== logic/sfp_pkg.sv
package sfp_pkg;
  // ---------------------------------------------------------------
  // timing and geometry
  // ---------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int PP_NS_DEF = 120000;
  localparam int PAGE_AW = 8;
  localparam int PAGE_BYTES = 256;
  localparam logic [7:0] PAGE_LAST = 8'hFF;
  localparam int ARR_AW = 12;
  localparam int PG_W = ARR_AW - PAGE_AW;
  localparam int SECT_W = 3;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [5:0] PIN_IDLE = 6'h10;
  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_PP_D = 8'hA2;
  localparam logic [7:0] OP_PP_DX = 8'hD2;
  localparam logic [7:0] OP_PP_Q = 8'h32;
  localparam logic [7:0] OP_PP_QX = 8'h38;
  localparam logic [7:0] OP_PP4 = 8'h12;
  localparam logic [7:0] OP_PP4_Q = 8'h34;
  localparam logic [7:0] OP_PP4_QX = 8'h3E;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_RDFSR = 8'h70;
  localparam logic [7:0] OP_CLRFS = 8'h50;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_EN4 = 8'hB7;
  localparam logic [7:0] OP_EX4 = 8'hE9;
  localparam logic [2:0] ADDR3 = 3'h3;
  localparam logic [2:0] ADDR4 = 3'h4;
  // ---------------------------------------------------------------
  // status fields and register map
  // ---------------------------------------------------------------
  localparam int SR_WIP = 0;
  localparam int SR_WEL = 1;
  localparam int FS_READY = 7;
  localparam int FS_PFAIL = 4;
  localparam int FS_PSUSP = 2;
  localparam int FS_PROT = 1;
  localparam int FS_ADDR4 = 0;
  localparam logic [3:0] SO_OE = 4'h2;
  localparam logic [7:0] RA_CTRL = 8'h00;
  localparam logic [7:0] RA_PROT = 8'h04;
  localparam logic [7:0] RA_STAT = 8'h08;
  localparam logic [7:0] RA_AADDR = 8'h0C;
  localparam logic [7:0] RA_ADATA = 8'h10;
  localparam int CT_NV4 = 0;
  localparam int CT_FAIL = 1;

  typedef enum logic [2:0] {LK_CMD, LK_ADDR, LK_DATA, LK_OUT, LK_SKIP} sfp_link_st_t;
  typedef enum logic [1:0] {PG_IDLE, PG_RUN, PG_SUSP, PG_COMMIT} sfp_prog_st_t;

  function automatic logic is_prog(input logic [7:0] op);
    return op inside {OP_PP, OP_PP_D, OP_PP_DX, OP_PP_Q, OP_PP_QX, OP_PP4, OP_PP4_Q, OP_PP4_QX};
  endfunction : is_prog

  function automatic logic is_4b(input logic [7:0] op);
    return op inside {OP_PP4, OP_PP4_Q, OP_PP4_QX}; // RULE12
  endfunction : is_4b

  // lines per clock for the address or data phase
  function automatic logic [3:0] lane_w(input logic [7:0] op, input logic data_ph);
    case (op)
      OP_PP_D: return data_ph ? 4'h2 : 4'h1; // RULE3
      OP_PP_DX: return 4'h2; // RULE3
      OP_PP_Q, OP_PP4_Q: return data_ph ? 4'h4 : 4'h1; // RULE4 RULE12
      OP_PP_QX, OP_PP4_QX: return 4'h4; // RULE4 RULE12
      default: return 4'h1; // RULE2
    endcase
  endfunction : lane_w

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] d, input logic [3:0] w);
    case (w)
      4'h2: return {sh[5:0], d[1:0]};
      4'h4: return {sh[3:0], d};
      default: return {sh[6:0], d[0]};
    endcase
  endfunction : shift_in
endpackage : sfp_pkg

// ===== logic/sfp_ifs.sv
interface sfp_link_if;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_low;
  logic [3:0] dq;
  modport src(output sclk_rise, sclk_fall, cs_rise, cs_low, dq);
  modport dst(input sclk_rise, sclk_fall, cs_rise, cs_low, dq);
endinterface : sfp_link_if

interface sfp_mem_if;
  logic buf_we;
  logic buf_clr;
  logic [7:0] buf_idx;
  logic [7:0] buf_data;
  logic commit_we;
  logic [7:0] commit_idx;
  logic [sfp_pkg::PG_W-1:0] page;
  logic [sfp_pkg::ARR_AW-1:0] rd_addr;
  logic [7:0] rd_data;
  modport ctl(output buf_we, buf_clr, buf_idx, buf_data, commit_we, commit_idx, page, rd_addr, input rd_data);
  modport mem(input buf_we, buf_clr, buf_idx, buf_data, commit_we, commit_idx, page, rd_addr, output rd_data);
endinterface : sfp_mem_if

// ===== logic/sfp_link_sync.sv
module sfp_link_sync (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // raw pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dq,
  // filtered view
  sfp_link_if.src lk
);
  logic [5:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;

  // ---------------------------------------------------------------
  // three-stage sampling, change accepted when stages two and three agree
  // ---------------------------------------------------------------
  always_comb begin
    filt_nxt = (filt_r & (s2_r ^ s3_r)) | (s2_r & ~(s2_r ^ s3_r));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= sfp_pkg::PIN_IDLE;
      s2_r <= sfp_pkg::PIN_IDLE;
      s3_r <= sfp_pkg::PIN_IDLE;
      filt_r <= sfp_pkg::PIN_IDLE;
      lk.sclk_rise <= 1'b0;
      lk.sclk_fall <= 1'b0;
      lk.cs_rise <= 1'b0;
      lk.cs_low <= 1'b0;
      lk.dq <= 4'h0;
    end else if (ce) begin
      s1_r <= {sclk, cs_n, dq};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
      lk.sclk_rise <= filt_nxt[5] & ~filt_r[5];
      lk.sclk_fall <= ~filt_nxt[5] & filt_r[5];
      lk.cs_rise <= filt_nxt[4] & ~filt_r[4];
      lk.cs_low <= ~filt_nxt[4];
      lk.dq <= filt_nxt[3:0];
    end
  end
endmodule : sfp_link_sync

// ===== logic/sfp_page_mem.sv
module sfp_page_mem (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // buffer and array access
  sfp_mem_if.mem m
);
  logic [7:0] buf_r [sfp_pkg::PAGE_BYTES];
  logic [7:0] arr_r [2**sfp_pkg::ARR_AW];
  logic [sfp_pkg::PAGE_BYTES-1:0] vld_r, vld_nxt;
  logic [sfp_pkg::ARR_AW-1:0] ca;
  logic [sfp_pkg::ARR_AW-1:0] a_h;
  logic [7:0] old_h;
  logic we_h, vh;

  assign ca = {m.page, m.commit_idx};
  assign m.rd_data = arr_r[m.rd_addr];

  // ---------------------------------------------------------------
  // page buffer with per-byte valid marks
  // ---------------------------------------------------------------
  always_comb begin
    vld_nxt = vld_r;
    if (m.buf_clr) begin
      vld_nxt = '0;
    end else if (m.buf_we) begin
      vld_nxt[m.buf_idx] = 1'b1; // RULE21
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vld_r <= '0;
    end else if (ce) begin
      vld_r <= vld_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && m.buf_we) begin
      buf_r[m.buf_idx] <= m.buf_data; // RULE10
    end
  end

  // ---------------------------------------------------------------
  // array: only unmarked bytes skipped, bits only cleared
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 2**sfp_pkg::ARR_AW; i++) begin
        arr_r[i] <= sfp_pkg::ERASED;
      end
    end else if (ce && m.commit_we && vld_r[m.commit_idx]) begin // RULE11
      arr_r[ca] <= arr_r[ca] & buf_r[m.commit_idx]; // RULE1
    end
  end

  always_ff @(posedge clk) begin
    we_h <= ce && m.commit_we;
    vh <= vld_r[m.commit_idx];
    a_h <= ca;
    old_h <= arr_r[ca];
  end

  one_to_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    we_h |-> (arr_r[a_h] & ~old_h) == 8'h00) else $error("programming raised a bit");
  untouched_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    (we_h && !vh) |-> arr_r[a_h] == old_h) else $error("unsent byte was changed");
endmodule : sfp_page_mem

// ===== logic/sfp_page_prog.sv
// Function
// RULE1: programming only clears bits, never sets them
// RULE2: opcode 02h single line address and data
// RULE3: A2h dual data, D2h dual address and data
// RULE4: 32h quad data, 38h quad address and data
// RULE5: write in progress high while programming
// RULE6: write enable cleared at every program end
// RULE7: status and flag reads answered while busy
// RULE8: suspend pauses, resume continues the program
// RULE9: bytes past page end wrap within page
// RULE10: overflow keeps only last page of bytes
// RULE11: unsent bytes of the page stay unchanged
// RULE12: 12h, 34h, 3Eh are four-byte address programs
// RULE13: four-byte mode captures a full 32-bit address
// RULE14: address width set by config or commands
// RULE15: four-byte opcodes always take four address bytes
// RULE16: host must set write enable before programming
// RULE17: no byte boundary at select rise, nothing happens
// RULE18: protected target refused, flags 1 and 4 set
// RULE19: timeout clears write enable, sets program fail
// RULE20: page size and program time are parameters; only program time is, page size is fixed PAGE_BYTES
// RULE21: buffer page, start array write at select rise
module sfp_page_prog #(
  parameter int PP_NS = sfp_pkg::PP_NS_DEF, // RULE20
  parameter int PP_CYC = (PP_NS + sfp_pkg::CLK_NS - 1) / sfp_pkg::CLK_NS
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe
);
  sfp_link_if lk();
  sfp_mem_if mi();

  sfp_link_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .sclk(sclk),
    .cs_n(cs_n),
    .dq(dq_in),
    .lk(lk)
  );

  sfp_page_mem u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .m(mi)
  );

  sfp_pkg::sfp_link_st_t link_r, link_nxt;
  sfp_pkg::sfp_prog_st_t prog_r, prog_nxt;
  logic [7:0] op_r, op_nxt, sh_r, sh_nxt, osh_r, osh_nxt, dcnt_r, dcnt_nxt, bv;
  logic [3:0] bits_r, bits_nxt, lw, nb, dqo_r, dqo_nxt, oe_r, oe_nxt;
  logic [2:0] obits_r, obits_nxt, abyt_r, abyt_nxt;
  logic [31:0] addr_r, addr_nxt, tmr_r, tmr_nxt, dat_r, dat_nxt;
  logic [7:0] cidx_r, cidx_nxt, prot_r, prot_nxt, stat_b, flag_b;
  logic [sfp_pkg::PG_W-1:0] page_r, page_nxt;
  logic [sfp_pkg::ARR_AW-1:0] raddr_r, raddr_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic got_r, got_nxt, wel_r, wel_nxt, mode4_r, mode4_nxt;
  logic ffail_r, ffail_nxt, fprot_r, fprot_nxt, ack_r, ack_nxt;
  logic bdone, start_ok, cmd_end, susp_cmd, res_cmd, prot_hit, acc, wr;

  // ---------------------------------------------------------------
  // status bytes
  // ---------------------------------------------------------------
  always_comb begin
    stat_b = 8'h00;
    stat_b[sfp_pkg::SR_WIP] = prog_r != sfp_pkg::PG_IDLE; // RULE5
    stat_b[sfp_pkg::SR_WEL] = wel_r;
    flag_b = 8'h00;
    flag_b[sfp_pkg::FS_READY] = prog_r == sfp_pkg::PG_IDLE || prog_r == sfp_pkg::PG_SUSP;
    flag_b[sfp_pkg::FS_PFAIL] = ffail_r;
    flag_b[sfp_pkg::FS_PSUSP] = prog_r == sfp_pkg::PG_SUSP;
    flag_b[sfp_pkg::FS_PROT] = fprot_r;
    flag_b[sfp_pkg::FS_ADDR4] = mode4_r;
  end

  // ---------------------------------------------------------------
  // link receiver and status output
  // ---------------------------------------------------------------
  always_comb begin
    link_nxt = link_r;
    op_nxt = op_r;
    sh_nxt = sh_r;
    osh_nxt = osh_r;
    bits_nxt = bits_r;
    obits_nxt = obits_r;
    abyt_nxt = abyt_r;
    addr_nxt = addr_r;
    dcnt_nxt = dcnt_r;
    got_nxt = got_r;
    dqo_nxt = dqo_r;
    oe_nxt = oe_r;
    lw = (link_r == sfp_pkg::LK_ADDR || link_r == sfp_pkg::LK_DATA) ?
         sfp_pkg::lane_w(op_r, link_r == sfp_pkg::LK_DATA) : 4'h1;
    bv = sfp_pkg::shift_in(sh_r, lk.dq, lw);
    nb = bits_r + lw;
    bdone = nb == 4'h8;
    mi.buf_we = 1'b0;
    mi.buf_clr = 1'b0;
    mi.buf_idx = addr_r[sfp_pkg::PAGE_AW-1:0] + dcnt_r; // RULE9 RULE10
    mi.buf_data = bv;
    if (!lk.cs_low) begin
      link_nxt = sfp_pkg::LK_CMD;
      bits_nxt = 4'h0;
      oe_nxt = 4'h0;
    end else if (lk.sclk_rise && link_r != sfp_pkg::LK_OUT) begin
      sh_nxt = bv;
      bits_nxt = bdone ? 4'h0 : nb;
      if (bdone) begin
        unique case (link_r)
          sfp_pkg::LK_CMD: begin
            op_nxt = bv;
            link_nxt = sfp_pkg::LK_SKIP;
            if (sfp_pkg::is_prog(bv) && wel_r && prog_r == sfp_pkg::PG_IDLE) begin // RULE16
              link_nxt = sfp_pkg::LK_ADDR;
              abyt_nxt = (sfp_pkg::is_4b(bv) || mode4_r) ? sfp_pkg::ADDR4 : sfp_pkg::ADDR3; // RULE14 RULE15
              addr_nxt = 32'h0;
              dcnt_nxt = 8'h00;
              got_nxt = 1'b0;
              mi.buf_clr = 1'b1;
            end else if (bv == sfp_pkg::OP_RDSR || bv == sfp_pkg::OP_RDFSR) begin
              link_nxt = sfp_pkg::LK_OUT;
              osh_nxt = (bv == sfp_pkg::OP_RDSR) ? stat_b : flag_b;
              obits_nxt = 3'h0;
            end
          end
          sfp_pkg::LK_ADDR: begin
            addr_nxt = {addr_r[23:0], bv}; // RULE13
            abyt_nxt = abyt_r - 3'h1;
            if (abyt_r == 3'h1) begin
              link_nxt = sfp_pkg::LK_DATA;
            end
          end
          sfp_pkg::LK_DATA: begin
            mi.buf_we = 1'b1; // RULE21
            dcnt_nxt = dcnt_r + 8'h01;
            got_nxt = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end else if (lk.sclk_fall && link_r == sfp_pkg::LK_OUT) begin
      dqo_nxt = osh_r[7] ? sfp_pkg::SO_OE : 4'h0; // RULE7
      oe_nxt = sfp_pkg::SO_OE;
      obits_nxt = obits_r + 3'h1;
      osh_nxt = {osh_r[6:0], 1'b0};
      if (obits_r == 3'h7) begin
        osh_nxt = (op_r == sfp_pkg::OP_RDSR) ? stat_b : flag_b;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_r <= sfp_pkg::LK_CMD;
      op_r <= 8'h00;
      sh_r <= 8'h00;
      osh_r <= 8'h00;
      bits_r <= 4'h0;
      obits_r <= 3'h0;
      abyt_r <= 3'h0;
      addr_r <= 32'h0;
      dcnt_r <= 8'h00;
      got_r <= 1'b0;
      dqo_r <= 4'h0;
      oe_r <= 4'h0;
    end else if (ce) begin
      link_r <= link_nxt;
      op_r <= op_nxt;
      sh_r <= sh_nxt;
      osh_r <= osh_nxt;
      bits_r <= bits_nxt;
      obits_r <= obits_nxt;
      abyt_r <= abyt_nxt;
      addr_r <= addr_nxt;
      dcnt_r <= dcnt_nxt;
      got_r <= got_nxt;
      dqo_r <= dqo_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ---------------------------------------------------------------
  // command execution and program engine
  // ---------------------------------------------------------------
  assign start_ok = lk.cs_rise && link_r == sfp_pkg::LK_DATA && bits_r == 4'h0 && got_r; // RULE17 RULE21
  assign cmd_end = lk.cs_rise && link_r == sfp_pkg::LK_SKIP && bits_r == 4'h0;
  assign susp_cmd = cmd_end && op_r == sfp_pkg::OP_SUSP;
  assign res_cmd = cmd_end && op_r == sfp_pkg::OP_RESUME;
  assign prot_hit = prot_r[addr_r[sfp_pkg::ARR_AW-1 -: sfp_pkg::SECT_W]];

  always_comb begin
    prog_nxt = prog_r;
    tmr_nxt = tmr_r;
    cidx_nxt = cidx_r;
    page_nxt = page_r;
    wel_nxt = wel_r;
    mode4_nxt = mode4_r;
    ffail_nxt = ffail_r;
    fprot_nxt = fprot_r;
    mi.commit_we = 1'b0;
    mi.commit_idx = cidx_r;
    mi.page = page_r;
    if (cmd_end) begin
      case (op_r)
        sfp_pkg::OP_WREN: wel_nxt = 1'b1;
        sfp_pkg::OP_EN4: mode4_nxt = 1'b1; // RULE14
        sfp_pkg::OP_EX4: mode4_nxt = 1'b0; // RULE14
        sfp_pkg::OP_CLRFS: begin
          ffail_nxt = 1'b0;
          fprot_nxt = 1'b0;
        end
        default: begin
        end
      endcase
    end
    if (wr && wb_adr == sfp_pkg::RA_CTRL && wb_sel[0]) begin
      mode4_nxt = wb_dat_w[sfp_pkg::CT_NV4]; // RULE14
    end
    unique case (prog_r)
      sfp_pkg::PG_IDLE: begin
        if (start_ok && prot_hit) begin
          fprot_nxt = 1'b1; // RULE18
          ffail_nxt = 1'b1; // RULE18
        end else if (start_ok) begin
          prog_nxt = sfp_pkg::PG_RUN;
          tmr_nxt = 32'(PP_CYC - 1);
          page_nxt = addr_r[sfp_pkg::ARR_AW-1:sfp_pkg::PAGE_AW];
        end
      end
      sfp_pkg::PG_RUN: begin
        if (susp_cmd) begin
          prog_nxt = sfp_pkg::PG_SUSP; // RULE8
        end else if (tmr_r == 32'h0 && ctrl_r[sfp_pkg::CT_FAIL]) begin
          prog_nxt = sfp_pkg::PG_IDLE;
          wel_nxt = 1'b0; // RULE19
          ffail_nxt = 1'b1; // RULE19
        end else if (tmr_r == 32'h0) begin
          prog_nxt = sfp_pkg::PG_COMMIT;
          cidx_nxt = 8'h00;
        end else begin
          tmr_nxt = tmr_r - 32'h1;
        end
      end
      sfp_pkg::PG_SUSP: begin
        if (res_cmd) begin
          prog_nxt = sfp_pkg::PG_RUN; // RULE8
        end
      end
      sfp_pkg::PG_COMMIT: begin
        mi.commit_we = 1'b1;
        cidx_nxt = cidx_r + 8'h01;
        if (cidx_r == sfp_pkg::PAGE_LAST) begin
          prog_nxt = sfp_pkg::PG_IDLE; // RULE5
          wel_nxt = 1'b0; // RULE6
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prog_r <= sfp_pkg::PG_IDLE;
      tmr_r <= 32'h0;
      cidx_r <= 8'h00;
      page_r <= '0;
      wel_r <= 1'b0;
      mode4_r <= 1'b0;
      ffail_r <= 1'b0;
      fprot_r <= 1'b0;
    end else if (ce) begin
      prog_r <= prog_nxt;
      tmr_r <= tmr_nxt;
      cidx_r <= cidx_nxt;
      page_r <= page_nxt;
      wel_r <= wel_nxt;
      mode4_r <= mode4_nxt;
      ffail_r <= ffail_nxt;
      fprot_r <= fprot_nxt;
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  assign acc = wb_cyc && wb_stb;
  assign wr = acc && wb_we && ack_r;
  assign mi.rd_addr = raddr_r;

  always_comb begin
    ack_nxt = acc && !ack_r;
    dat_nxt = dat_r;
    ctrl_nxt = ctrl_r;
    prot_nxt = prot_r;
    raddr_nxt = raddr_r;
    if (acc && !ack_r) begin
      case (wb_adr)
        sfp_pkg::RA_CTRL: dat_nxt = 32'(ctrl_r);
        sfp_pkg::RA_PROT: dat_nxt = 32'(prot_r);
        sfp_pkg::RA_STAT: dat_nxt = 32'({flag_b, stat_b});
        sfp_pkg::RA_AADDR: dat_nxt = 32'(raddr_r);
        sfp_pkg::RA_ADATA: dat_nxt = 32'(mi.rd_data);
        default: dat_nxt = 32'h0;
      endcase
    end
    if (wr) begin
      case (wb_adr)
        sfp_pkg::RA_CTRL: if (wb_sel[0]) ctrl_nxt = wb_dat_w[1:0];
        sfp_pkg::RA_PROT: if (wb_sel[0]) prot_nxt = wb_dat_w[7:0];
        sfp_pkg::RA_AADDR: begin
          if (wb_sel[0]) raddr_nxt[7:0] = wb_dat_w[7:0];
          if (wb_sel[1]) raddr_nxt[sfp_pkg::ARR_AW-1:8] = wb_dat_w[sfp_pkg::ARR_AW-1:8];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      ctrl_r <= 2'h0;
      prot_r <= 8'h00;
      raddr_r <= '0;
    end else if (ce) begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      ctrl_r <= ctrl_nxt;
      prot_r <= prot_nxt;
      raddr_r <= raddr_nxt;
    end
  end

  assign wb_ack = ack_r;
  assign wb_dat_r = dat_r;
  assign dq_out = dqo_r;
  assign dq_oe = oe_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_start;
    ce && prog_r == sfp_pkg::PG_IDLE && start_ok && !prot_hit;
  endsequence
  sequence s_refused;
    ce && prog_r == sfp_pkg::PG_IDLE && start_ok && prot_hit;
  endsequence

  wip_hold_a: assert property (s_start |=> stat_b[sfp_pkg::SR_WIP] [*8]) else $error("wip not held"); // RULE5
  wel_end_a: assert property ($fell(stat_b[sfp_pkg::SR_WIP]) |-> !wel_r) else $error("wel kept at end"); // RULE6
  prot_flag_a: assert property (s_refused |=> prog_r == sfp_pkg::PG_IDLE && fprot_r && ffail_r && wel_r)
    else $error("protected program not refused"); // RULE18
  boundary_a: assert property (ce && lk.cs_rise && link_r == sfp_pkg::LK_DATA && bits_r != 4'h0
    |=> prog_r == sfp_pkg::PG_IDLE && $stable(wel_r) && $stable(ffail_r)) else $error("broken byte ran"); // RULE17
  suspend_a: assert property (ce && prog_r == sfp_pkg::PG_RUN && susp_cmd
    |=> prog_r == sfp_pkg::PG_SUSP && $stable(tmr_r)) else $error("suspend ignored"); // RULE8
  poll_busy_a: assert property (ce && prog_r != sfp_pkg::PG_IDLE && link_r == sfp_pkg::LK_OUT && lk.sclk_fall
    && lk.cs_low |=> oe_r == sfp_pkg::SO_OE) else $error("no status while busy"); // RULE7
  addr_four_a: assert property (ce && link_r == sfp_pkg::LK_CMD && lk.cs_low && lk.sclk_rise && bdone
    && sfp_pkg::is_4b(bv) && wel_r && prog_r == sfp_pkg::PG_IDLE |=> abyt_r == sfp_pkg::ADDR4)
    else $error("four-byte opcode not four bytes"); // RULE15
  fail_end_a: assert property (ce && prog_r == sfp_pkg::PG_RUN && tmr_r == 32'h0 && ctrl_r[sfp_pkg::CT_FAIL]
    && !susp_cmd |=> ffail_r && !wel_r && prog_r == sfp_pkg::PG_IDLE) else $error("timeout not flagged"); // RULE19
  mode_cmd_a: assert property (ce && cmd_end && op_r == sfp_pkg::OP_EN4 && !wr |=> mode4_r)
    else $error("enter four-byte ignored"); // RULE14
endmodule : sfp_page_prog

// ===== verif/sfp_host.sv
module sfp_host (
  // clock
  input wire logic clk,
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic [3:0] dq,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx;
  initial {sclk, cs_n, dq, rx} = 14'h1500;
  // msb first, w lines a clock, sclk idles low
  task automatic put(input logic [7:0] b, input int w);
    for (int i = 8 - w; i >= 0; i -= w) begin
      dq <= 4'((b >> i) & ((1 << w) - 1));
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      {sclk, rx} <= {1'b0, rx[6:0], so};
    end
  endtask : put
  // released lines are left inverted
  task automatic sel(input logic on);
    repeat (4) @(posedge clk);
    {cs_n, dq} <= {~on, ~dq};
    repeat (8) @(posedge clk);
  endtask : sel
endmodule : sfp_host

// ===== verif/serial_flash_page_program_test.sv
module serial_flash_page_program_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] op; int n, aw, dw; logic [11:0] a; logic [7:0] d0, d1;} sfp_row_t;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, cyc = 1'b0, we = 1'b0, ack, sclk, cs_n;
  logic [7:0] adr = 8'h00, arr [4096] = '{default: 8'hFF};
  logic [31:0] dw = 32'h0, rd, dr;
  logic [11:0] x;
  logic [3:0] dq, so, oe, sel = 4'hF;
  int n_fail = 0, cmp_count = 0;
  sfp_row_t rows [9] = '{'{8'h02, 3, 1, 1, 12'h010, 8'h5A, 8'h3C}, '{8'hA2, 3, 1, 2, 12'h020, 8'hA5, 8'hC3},
    '{8'hD2, 3, 2, 2, 12'h0FF, 8'h12, 8'h34}, '{8'h32, 3, 1, 4, 12'h030, 8'h56, 8'h78},
    '{8'h38, 3, 4, 4, 12'h040, 8'h9A, 8'hBC}, '{8'h12, 4, 1, 1, 12'h050, 8'hDE, 8'hF0},
    '{8'h34, 4, 1, 4, 12'h060, 8'h01, 8'h23}, '{8'h3E, 4, 4, 4, 12'h070, 8'h45, 8'h67},
    '{8'h02, 3, 1, 1, 12'h010, 8'hF0, 8'h0F}};
  sfp_page_prog #(.PP_CYC(200)) u_sfp_page_prog (.clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc(cyc),
    .wb_stb(cyc), .wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dw), .wb_dat_r(dr), .wb_ack(ack),
    .sclk(sclk), .cs_n(cs_n), .dq_in(dq), .dq_out(so), .dq_oe(oe));
  sfp_host u_sfp_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .dq(dq), .so(oe[1] ? so[1] : ~so[1]));
  initial forever #2 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report(input int hung);
    n_fail += hung;
    $display("%0d compares %0d fails", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc, we, adr, dw} <= {1'b1, w, a, d};
    for (int k = 0; k <= 20; k++) begin
      @(posedge clk);
      if (k == 20) final_report(1);
      if (ack === 1'b1) break;
    end
    rd = dr;
    cyc <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic idle();
    for (int k = 0; k <= 300; k++) begin
      if (k == 300) final_report(1);
      wb(1'b0, 8'h08, 32'h0);
      if (rd[0] === 1'b0) break;
    end
  endtask : idle
  task automatic peek(input logic [11:0] a);
    wb(1'b1, 8'h0C, {20'h0, a});
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, {24'h0, arr[a]});
  endtask : peek
  task automatic cmd(input logic [7:0] op, input int nb);
    u_sfp_host.sel(1'b1);
    u_sfp_host.put(op, 1);
    repeat (nb) u_sfp_host.put(8'h00, 1);
    u_sfp_host.sel(1'b0);
  endtask : cmd
  task automatic prog(input sfp_row_t r, input logic [1:0] poll);
    cmd(8'h06, 0);
    u_sfp_host.sel(1'b1);
    u_sfp_host.put(r.op, 1);
    for (int k = r.n - 1; k >= 0; k--) u_sfp_host.put(8'({20'hABCDE, r.a} >> (8 * k)), r.aw);
    u_sfp_host.put(r.d0, r.dw);
    u_sfp_host.put(r.d1, r.dw);
    u_sfp_host.sel(1'b0);
    if (poll == 2'h1) cmd(8'h05, 1);
    if (poll == 2'h1) chk({30'h0, u_sfp_host.rx[1:0]}, 32'h3);
    if (poll == 2'h1) chk({28'h0, oe}, 32'h0);
    if (poll == 2'h2) begin
      cmd(8'h75, 0);
      repeat (400) @(posedge clk);
      cmd(8'h70, 1);
      chk({24'h0, u_sfp_host.rx} & 32'h84, 32'h84);
      wb(1'b0, 8'h08, 32'h0);
      chk(rd & 32'h0401, 32'h0401);
      cmd(8'h7A, 0);
    end
    idle();
  endtask : prog
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h8000);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    $display("reset done");
    foreach (rows[i]) begin
      prog(rows[i], {1'b0, i == 0});
      chk(rd & 32'h3, 32'h0);
      x = rows[i].a;
      arr[x] &= rows[i].d0;
      arr[{x[11:8], x[7:0] + 8'h01}] &= rows[i].d1;
      for (int k = 0; k < 3; k++) peek({x[11:8], x[7:0] + 8'(k)});
      $display("row %0d done", i);
    end
    cmd(8'h06, 0);
    u_sfp_host.sel(1'b1);
    u_sfp_host.put(8'h38, 1);
    u_sfp_host.put(8'h00, 4);
    u_sfp_host.put(8'h04, 4);
    u_sfp_host.put(8'h00, 4);
    for (int k = 0; k < 258; k++) u_sfp_host.put(k < 256 ? 8'(k) : 8'hA5, 4);
    u_sfp_host.sel(1'b0);
    idle();
    {arr[12'h400], arr[12'h401], arr[12'h402]} = 24'hA5A502;
    for (int k = 0; k < 3; k++) peek(12'h400 + 12'(k));
    $display("overflow done");
    wb(1'b1, 8'h04, 32'h2);
    prog(sfp_row_t'{8'h02, 3, 1, 1, 12'h210, 8'h00, 8'h00}, 2'h0);
    chk(rd & 32'h1203, 32'h1202);
    peek(12'h210);
    {ce, sel} <= {1'b0, 4'hE};
    fork
      wb(1'b1, 8'h04, 32'hFF);
      begin
        repeat (6) @(posedge clk);
        chk({31'h0, ack}, 32'h0);
        ce <= 1'b1;
      end
    join
    sel <= 4'hF;
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h2);
    cmd(8'h50, 0);
    prog(sfp_row_t'{8'h02, 3, 1, 4, 12'h0A0, 8'h00, 8'h00}, 2'h0);
    chk(rd & 32'h1203, 32'h2);
    peek(12'h0A0);
    wb(1'b1, 8'h00, 32'h2);
    prog(sfp_row_t'{8'h02, 3, 1, 1, 12'h0B0, 8'h00, 8'h00}, 2'h0);
    chk(rd & 32'h1003, 32'h1000);
    $display("fault done");
    wb(1'b1, 8'h00, 32'h1);
    prog(sfp_row_t'{8'h02, 4, 1, 1, 12'h0C0, 8'h81, 8'h18}, 2'h0);
    arr[12'h0C0] = 8'h81;
    peek(12'h0C0);
    cmd(8'hE9, 0);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h100, 32'h0);
    cmd(8'hB7, 0);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h100, 32'h100);
    $display("mode done");
    prog(sfp_row_t'{8'h02, 4, 1, 1, 12'h0D0, 8'h3C, 8'hC3}, 2'h2);
    arr[12'h0D0] = 8'h3C;
    arr[12'h0D1] = 8'hC3;
    peek(12'h0D0);
    peek(12'h0D1);
    $display("suspend done");
    final_report(0);
  end
endmodule : serial_flash_page_program_test
